//--- verilog/ctc_regs.svh
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH

`define CTC_ADDR_W 7
`define CTC_DATA_W 16
`define CTC_TEST_ADDR 7'h17
`define CTC_RESET 16'h0000
`define CTC_WMASK_CH0 16'hF7DF
`define CTC_WMASK_CHN 16'hF05F
`define CTC_PAD_LAT 2
`define CTC_STB_LAT 1
`define CTC_ROM_W 18
`define CTC_ROM_ONE 18'h1_FFFF
`define CTC_PN_W 16
`define CTC_PN_SEED 16'hACE1
`define CTC_PN_TAPS 16'hB400
`define CTC_HOLD_W 3

`endif

//--- verilog/ctc_pkg.sv
`include "ctc_regs.svh"

package ctc_pkg;

  // Field order follows the register bits, most significant first.
  typedef struct packed {
    logic sclk_bound;
    logic data_dly;
    logic stb_dly;
    logic coef_float;
    logic rsv11;
    logic hold_sd;
    logic hold_cs;
    logic hold_cas;
    logic pn_en;
    logic pn_fast;
    logic rsv5;
    logic thru;
    logic pn_sel;
    logic force_edge;
    logic force_fifo;
    logic force_rom;
  } ctc_ctrl_type;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [`CTC_ADDR_W-1:0] addr;
    logic [`CTC_DATA_W-1:0] data;
  } ctc_pins_type;

  typedef struct packed {
    logic frame_sync;
    logic bit_clock;
  } ctc_serial_type;

  typedef enum logic [1:0] {
    GATE_RUN,
    GATE_WAIT,
    GATE_OFF
  } ctc_gate_type;

endpackage : ctc_pkg

//--- verilog/ctc_pn_gen.sv
`timescale 1ns/1ps
`include "ctc_regs.svh"

module ctc_pn_gen
  import ctc_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic fast_in,
  input wire logic symbol_step_in,
  output logic [`CTC_PN_W-1:0] pn_word_out
);

  logic [`CTC_PN_W-1:0] lfsr_reg;
  logic [`CTC_PN_W-1:0] lfsr_next;

  // Galois form of a maximal-length 16-bit polynomial; a nonzero seed
  // keeps it out of the all-zero lock-up state.
  always_comb begin
    lfsr_next = lfsr_reg;
    if (enable_in && (fast_in || symbol_step_in)) begin // see R6 see R7 see R14
      lfsr_next = {1'b0, lfsr_reg[`CTC_PN_W-1:1]};
      if (lfsr_reg[0]) begin
        lfsr_next = lfsr_next ^ `CTC_PN_TAPS;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lfsr_reg <= `CTC_PN_SEED;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign pn_word_out = lfsr_reg;

endmodule : ctc_pn_gen

//--- verilog/ctc_test_control.sv
// Contract
// R1: Bit15 chooses immediate or bit-clock-boundary serial stop.
// R2: Bit14 delays serial data by pad latency.
// R3: Bit13 delays and aligns the oversample strobe.
// R4: Host sets both 14 and 13 for gapless.
// R5: Bit12 selects floating coefficient format.
// R6: Bit7 enables the pseudo-noise generator.
// R7: Bit6 picks clock rate or symbol rate.
// R8: Bit4 routes FIFO straight to interpolator.
// R9: Bit3 feeds FIFO from pseudo-noise generator.
// R10: Bit2 steps filters every clock.
// R11: Bit1 reads FIFO every clock.
// R12: Bit0 forces carrier sine and cosine high.
// R13: Bits 10..7 only in channel zero.
// R14: Generator is maximal LFSR, own polynomial.
// R15: Reserved bits 11 and 5 read zero.
`timescale 1ns/1ps
`include "ctc_regs.svh"

module ctc_test_control
  import ctc_pkg::*;
#(
  parameter int CHAN_INDEX = 0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic up_cs_n_in,
  input wire logic up_wr_n_in,
  input wire logic up_rd_n_in,
  input wire logic [`CTC_ADDR_W-1:0] up_addr_in,
  input wire logic [`CTC_DATA_W-1:0] up_data_in,
  output logic [`CTC_DATA_W-1:0] up_data_out,
  output logic up_data_oe_out,
  input wire logic serial_stop_in,
  input wire logic serial_frame_sync_int_in,
  input wire logic serial_bit_clock_int_in,
  output logic serial_frame_sync_out,
  output logic serial_bit_clock_out,
  input wire logic serial_data_int_in,
  output logic serial_data_out,
  input wire logic serial_oversample_strobe_in,
  output logic serial_oversample_strobe_out,
  input wire logic symbol_step_in,
  input wire logic [`CTC_DATA_W-1:0] fifo_src_data_in,
  output logic [`CTC_DATA_W-1:0] fifo_src_data_out,
  input wire logic nco_fifo_read_in,
  output logic fifo_read_out,
  input wire logic nco_filter_step_in,
  output logic filter_step_out,
  output logic straight_thru_out,
  output logic coef_float_out,
  input wire logic [`CTC_ROM_W-1:0] rom_sin_in,
  input wire logic [`CTC_ROM_W-1:0] rom_cos_in,
  output logic [`CTC_ROM_W-1:0] rom_sin_out,
  output logic [`CTC_ROM_W-1:0] rom_cos_out,
  output logic [`CTC_HOLD_W-1:0] hold_sel_out
);

  function automatic logic addr_hit(input ctc_pins_type p);
    addr_hit = !p.cs_n && (p.addr == `CTC_TEST_ADDR);
  endfunction : addr_hit

  // Host pins: two-stage synchroniser, then an edge detector on stage two.
  ctc_pins_type pins_in;
  ctc_pins_type sync1_reg;
  ctc_pins_type sync2_reg;
  logic wr_prev_reg;
  logic write_evt;

  assign pins_in = '{cs_n: up_cs_n_in, wr_n: up_wr_n_in, rd_n: up_rd_n_in,
                     addr: up_addr_in, data: up_data_in};

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      wr_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      wr_prev_reg <= sync2_reg.wr_n;
    end
  end

  // The write lands on the trailing edge of the strobe, when data has settled.
  assign write_evt = !wr_prev_reg && sync2_reg.wr_n && addr_hit(sync2_reg);

  // Control register.
  ctc_ctrl_type ctrl_reg;
  ctc_ctrl_type ctrl_next;
  logic [`CTC_DATA_W-1:0] wmask;
  logic [`CTC_DATA_W-1:0] rdata_reg;
  logic [`CTC_DATA_W-1:0] rdata_next;
  logic roe_reg;
  logic roe_next;

  // Other channels cannot hold the channel-zero test bits at all.
  assign wmask = (CHAN_INDEX == 0) ? `CTC_WMASK_CH0 : `CTC_WMASK_CHN; // see R13 see R15

  always_comb begin
    ctrl_next = ctrl_reg;
    if (write_evt) begin
      ctrl_next = ctc_ctrl_type'(sync2_reg.data & wmask); // see R13 see R15
    end
    roe_next = addr_hit(sync2_reg) && !sync2_reg.rd_n;
    rdata_next = roe_next ? ctrl_reg : `CTC_RESET;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= `CTC_RESET;
      rdata_reg <= `CTC_RESET;
      roe_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      roe_reg <= roe_next;
    end
  end

  assign up_data_out = rdata_reg;
  assign up_data_oe_out = roe_reg;

  // Serial frame sync and bit clock gating.
  ctc_gate_type gate_reg;
  ctc_gate_type gate_next;
  ctc_serial_type ser_reg;
  ctc_serial_type ser_next;

  always_comb begin
    gate_next = gate_reg;
    case (gate_reg)
      GATE_RUN: begin
        if (serial_stop_in) begin
          if (!ctrl_reg.sclk_bound || !serial_bit_clock_int_in) begin // see R1
            gate_next = GATE_OFF;
          end else begin
            gate_next = GATE_WAIT;
          end
        end
      end
      GATE_WAIT: begin
        // Holding until the clock is low avoids a truncated high phase.
        if (!serial_stop_in) begin
          gate_next = GATE_RUN;
        end else if (!serial_bit_clock_int_in || !ctrl_reg.sclk_bound) begin // see R1
          gate_next = GATE_OFF;
        end
      end
      GATE_OFF: begin
        if (!serial_stop_in) begin
          gate_next = GATE_RUN;
        end
      end
      default: begin
        gate_next = GATE_OFF;
      end
    endcase
    ser_next.frame_sync = (gate_next != GATE_OFF) && serial_frame_sync_int_in;
    ser_next.bit_clock = (gate_next != GATE_OFF) && serial_bit_clock_int_in;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_reg <= GATE_RUN;
      ser_reg <= '0;
    end else begin
      gate_reg <= gate_next;
      ser_reg <= ser_next;
    end
  end

  assign serial_frame_sync_out = ser_reg.frame_sync;
  assign serial_bit_clock_out = ser_reg.bit_clock;

  // Serial data and strobe alignment delays. The host is expected to set
  // both for gapless words; either alone still acts on its own path.
  logic [`CTC_PAD_LAT-1:0] dly_reg;
  logic [`CTC_PAD_LAT-1:0] dly_next;
  logic [`CTC_STB_LAT-1:0] stb_reg;
  logic [`CTC_STB_LAT-1:0] stb_next;
  logic sdata_reg;
  logic sdata_next;
  logic sstb_reg;
  logic sstb_next;

  always_comb begin
    dly_next = {dly_reg[`CTC_PAD_LAT-2:0], serial_data_int_in};
    stb_next = serial_oversample_strobe_in;
    sdata_next = ctrl_reg.data_dly ? dly_reg[`CTC_PAD_LAT-1] : serial_data_int_in; // see R2 see R4
    sstb_next = ctrl_reg.stb_dly ? stb_reg[`CTC_STB_LAT-1] : // see R3 see R4
                serial_oversample_strobe_in;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dly_reg <= '0;
      stb_reg <= '0;
      sdata_reg <= 1'b0;
      sstb_reg <= 1'b0;
    end else begin
      dly_reg <= dly_next;
      stb_reg <= stb_next;
      sdata_reg <= sdata_next;
      sstb_reg <= sstb_next;
    end
  end

  assign serial_data_out = sdata_reg;
  assign serial_oversample_strobe_out = sstb_reg;

  // Pseudo-noise source.
  logic [`CTC_PN_W-1:0] pn_word;

  ctc_pn_gen u_pn_gen (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .enable_in(ctrl_reg.pn_en), // see R6
    .fast_in(ctrl_reg.pn_fast), // see R7
    .symbol_step_in(symbol_step_in),
    .pn_word_out(pn_word)
  );

  // Datapath overrides, all registered so the outputs come from flops.
  logic [`CTC_DATA_W-1:0] fdata_reg;
  logic [`CTC_DATA_W-1:0] fdata_next;
  logic [`CTC_ROM_W-1:0] sin_reg;
  logic [`CTC_ROM_W-1:0] sin_next;
  logic [`CTC_ROM_W-1:0] cos_reg;
  logic [`CTC_ROM_W-1:0] cos_next;
  logic fread_reg;
  logic fread_next;
  logic fstep_reg;
  logic fstep_next;

  always_comb begin
    fdata_next = ctrl_reg.pn_sel ? pn_word : fifo_src_data_in; // see R9
    fread_next = ctrl_reg.force_fifo || nco_fifo_read_in; // see R11
    fstep_next = ctrl_reg.force_edge || nco_filter_step_in; // see R10
    sin_next = ctrl_reg.force_rom ? `CTC_ROM_ONE : rom_sin_in; // see R12
    cos_next = ctrl_reg.force_rom ? `CTC_ROM_ONE : rom_cos_in; // see R12
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fdata_reg <= '0;
      fread_reg <= 1'b0;
      fstep_reg <= 1'b0;
      sin_reg <= '0;
      cos_reg <= '0;
    end else begin
      fdata_reg <= fdata_next;
      fread_reg <= fread_next;
      fstep_reg <= fstep_next;
      sin_reg <= sin_next;
      cos_reg <= cos_next;
    end
  end

  assign fifo_src_data_out = fdata_reg;
  assign fifo_read_out = fread_reg;
  assign filter_step_out = fstep_reg;
  assign rom_sin_out = sin_reg;
  assign rom_cos_out = cos_reg;
  assign straight_thru_out = ctrl_reg.thru; // see R8
  assign coef_float_out = ctrl_reg.coef_float; // see R5
  assign hold_sel_out = {ctrl_reg.hold_sd, ctrl_reg.hold_cs, ctrl_reg.hold_cas}; // see R13

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  chk_stop_sync: assert property ( // see R1
    !ctrl_reg.sclk_bound && serial_stop_in |=> !serial_bit_clock_out && !serial_frame_sync_out)
    else $error("serial outputs not stopped at once");

  chk_stop_boundary: assert property ( // see R1
    ctrl_reg.sclk_bound && gate_reg == GATE_RUN && serial_bit_clock_int_in
    |=> serial_bit_clock_out)
    else $error("bit clock cut inside a high phase");

  chk_data_delay: assert property ( // see R2
    $past(ctrl_reg.data_dly) && $past(ctrl_reg.data_dly, 2) && $past(ctrl_reg.data_dly, 3)
    |-> serial_data_out == $past(serial_data_int_in, 3))
    else $error("serial data delay wrong");

  chk_strobe_delay: assert property ( // see R3
    $past(ctrl_reg.stb_dly) |-> serial_oversample_strobe_out == $past(serial_oversample_strobe_in, 2))
    else $error("oversample strobe delay wrong");

  chk_coef_write: assert property ( // see R5
    write_evt |=> coef_float_out == $past(sync2_reg.data[`CTC_DATA_W-4]))
    else $error("coefficient format not taken from write");

  chk_pn_idle: assert property ( // see R6
    $past(!ctrl_reg.pn_en) |-> $stable(pn_word))
    else $error("generator moved while disabled");

  chk_pn_fast: assert property ( // see R7
    $past(ctrl_reg.pn_en && ctrl_reg.pn_fast) |-> !$stable(pn_word))
    else $error("generator idle at clock rate");

  chk_pn_source: assert property ( // see R9
    $past(ctrl_reg.pn_sel) |-> fifo_src_data_out == $past(pn_word))
    else $error("FIFO input not from generator");

  chk_force_step: assert property ( // see R10 see R11
    $past(ctrl_reg.force_edge) && $past(ctrl_reg.force_fifo) |-> filter_step_out && fifo_read_out)
    else $error("forced stepping missing");

  chk_force_rom: assert property ( // see R12
    $past(ctrl_reg.force_rom) |-> rom_sin_out == `CTC_ROM_ONE && rom_cos_out == `CTC_ROM_ONE)
    else $error("carrier ROM not forced");

  chk_upper_clear: assert property ( // see R13
    CHAN_INDEX != 0 |-> !ctrl_reg.pn_en && hold_sel_out == '0)
    else $error("channel-zero bits set in other channel");

  chk_reserved_zero: assert property ( // see R15
    !ctrl_reg.rsv11 && !ctrl_reg.rsv5)
    else $error("reserved bits not zero");

endmodule : ctc_test_control

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "ctc_regs.svh"

module tb_top
  import ctc_pkg::*;
;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  ctc_pins_type bus;
  ctc_serial_type ser_in;
  logic stop, sd, stb, sym, nfr, nfs;
  logic [15:0] fsrc;
  logic [17:0] rsin, rcos;
  logic [15:0] rd_d [2];
  logic rd_oe [2];
  logic fso [2];
  logic bco [2];
  logic sd_o [2];
  logic stb_o [2];
  logic [15:0] fifo_o [2];
  logic fr_o [2];
  logic fs_o [2];
  logic thru_o [2];
  logic cf_o [2];
  logic [17:0] sin_o [2];
  logic [17:0] cos_o [2];
  logic [2:0] hold_o [2];
  integer num_errors = 0;
  integer tests_run = 0;
  logic [31:0] rs;

  always #10 clk_in = ~clk_in;

  // Channel 1 stands for all upper channels, where the channel-zero test bits are cleared.
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    ctc_test_control #(.CHAN_INDEX(g)) ctc_test_control_i (
      .clk_in(clk_in), .nrst_in(nrst_in),
      .up_cs_n_in(bus.cs_n), .up_wr_n_in(bus.wr_n), .up_rd_n_in(bus.rd_n),
      .up_addr_in(bus.addr), .up_data_in(bus.data),
      .up_data_out(rd_d[g]), .up_data_oe_out(rd_oe[g]),
      .serial_stop_in(stop), .serial_frame_sync_int_in(ser_in.frame_sync),
      .serial_bit_clock_int_in(ser_in.bit_clock),
      .serial_frame_sync_out(fso[g]), .serial_bit_clock_out(bco[g]),
      .serial_data_int_in(sd), .serial_data_out(sd_o[g]),
      .serial_oversample_strobe_in(stb), .serial_oversample_strobe_out(stb_o[g]),
      .symbol_step_in(sym), .fifo_src_data_in(fsrc), .fifo_src_data_out(fifo_o[g]),
      .nco_fifo_read_in(nfr), .fifo_read_out(fr_o[g]),
      .nco_filter_step_in(nfs), .filter_step_out(fs_o[g]),
      .straight_thru_out(thru_o[g]), .coef_float_out(cf_o[g]),
      .rom_sin_in(rsin), .rom_cos_in(rcos), .rom_sin_out(sin_o[g]), .rom_cos_out(cos_o[g]),
      .hold_sel_out(hold_o[g])
    );
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd

  function automatic logic [15:0] stp(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
  endfunction : stp

  task automatic results();
    $display("errors %0d compares %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // One compare task per result width, so no argument is silently padded.
  task automatic chk_bit(input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_bit

  task automatic chk_hold(input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_hold

  task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_word

  task automatic chk_rom(input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_rom

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  // Strobe phases are four clocks long so the two-flop pin synchroniser always sees them.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_in);
    bus = '{1'b0, 1'b0, 1'b1, a, d};
    cyc(4);
    bus.wr_n = 1'b1;
    cyc(4);
    bus.cs_n = 1'b1;
    cyc(4);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [15:0] d0, d1, output logic oe);
    @(negedge clk_in);
    bus = '{1'b0, 1'b1, 1'b0, a, 16'h0000};
    cyc(5);
    d0 = rd_d[0];
    d1 = rd_d[1];
    oe = rd_oe[0];
    bus = '{1'b1, 1'b1, 1'b1, a, 16'h0000};
    cyc(5);
  endtask : rd

  task automatic chkreg(input logic [15:0] v);
    logic [15:0] d0, d1;
    logic oe;
    rd(7'h17, d0, d1, oe);
    chk_word(v & 16'hF7DF, d0);
    chk_word(v & 16'hF05F, d1);
    chk_bit(1'b1, oe);
  endtask : chkreg

  initial begin
    #400_000;
    num_errors++;
    results();
  end

  initial begin
    logic [15:0] v, p, d0, d1;
    logic [31:0] r;
    logic [2:0] hsd, hst;
    logic oe;
    rs = 32'h0000_000E;
    bus = '{1'b1, 1'b1, 1'b1, 7'h00, 16'h0000};
    ser_in = '{1'b0, 1'b0};
    {stop, sd, stb, sym, nfr, nfs} = 6'h00;
    fsrc = 16'h0000;
    rsin = 18'h0_0000;
    rcos = 18'h0_0000;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    chkreg(16'h0000);
    chk_bit(1'b0, cf_o[0]);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : r[15:0];
      wr(7'h17, v);
      chkreg(v);
      chk_bit(v[12], cf_o[0]);
      chk_bit(v[4], thru_o[0]);
      chk_hold(v[10:8], hold_o[0]);
      chk_hold(3'h0, hold_o[1]);
      r = rnd();
      {nfr, nfs, fsrc} = r[17:0];
      rsin = 18'(rnd());
      rcos = 18'(rnd());
      cyc(1);
      chk_bit(nfr | v[1], fr_o[0]);
      chk_bit(nfs | v[2], fs_o[0]);
      chk_rom(v[0] ? 18'h1_FFFF : rsin, sin_o[0]);
      chk_rom(v[0] ? 18'h1_FFFF : rcos, cos_o[0]);
      if (!v[3]) chk_word(fsrc, fifo_o[0]);
    end
    wr(7'h16, 16'h0F0F);
    chkreg(v);
    rd(7'h16, d0, d1, oe);
    chk_bit(1'b0, oe);
    chk_word(16'h0000, d0);
    for (int m = 0; m < 4; m++) begin
      wr(7'h17, {1'b0, m[1:0], 13'h0000});
      hsd = 3'h0;
      hst = 3'h0;
      for (int i = 0; i < 12; i++) begin
        if (i > 3) begin
          chk_bit(hsd[m[1] ? 2 : 0], sd_o[0]);
          chk_bit(hst[m[0] ? 1 : 0], stb_o[0]);
        end
        r = rnd();
        sd = r[0];
        stb = r[1];
        hsd = {hsd[1:0], r[0]};
        hst = {hst[1:0], r[1]};
        cyc(1);
      end
    end
    for (int b = 0; b < 2; b++) begin
      wr(7'h17, {b[0], 15'h0000});
      ser_in = '{1'b1, 1'b1};
      cyc(2);
      stop = 1'b1;
      if (b == 1) begin
        cyc(3);
        chk_bit(1'b1, bco[0]);
        ser_in.bit_clock = 1'b0;
      end
      cyc(2);
      chk_bit(1'b0, fso[0]);
      chk_bit(1'b0, bco[0]);
      stop = 1'b0;
      ser_in = '{1'b1, 1'b1};
      cyc(2);
      chk_bit(1'b1, fso[0]);
    end
    // The generator sequence is checked step against step, so the seed phase does not matter.
    wr(7'h17, 16'h0088);
    p = fifo_o[0];
    cyc(3);
    chk_word(p, fifo_o[0]);
    sym = 1'b1;
    cyc(1);
    sym = 1'b0;
    cyc(2);
    chk_word(stp(p), fifo_o[0]);
    wr(7'h17, 16'h00C8);
    for (int i = 0; i < 6; i++) begin
      p = fifo_o[0];
      d1 = fifo_o[1];
      cyc(1);
      chk_word(stp(p), fifo_o[0]);
      chk_word(d1, fifo_o[1]);
    end
    wr(7'h17, 16'h0048);
    p = fifo_o[0];
    cyc(3);
    chk_word(p, fifo_o[0]);
    results();
  end
endmodule : tb_top
